// ==== dv/mem_ctrl_model.sv ====
/*
 * Behavioural memory controller driving the burst memory port from a
 * queue of slots and logging what the port answers.
 * Assumes the bench fills the queue through put() and empties got.
 */
`timescale 1ns/1ps
module mem_ctrl_model
    import sram_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command pins
    output logic [ADDR_W-1:0] addr,
    output logic advanceLoad,
    output logic writeEnableN,
    output logic [LANES-1:0] byteLaneWriteSelectsN,
    output logic chipSelectOneN,
    output logic chipSelectTwo,
    output logic chipSelectThreeN,
    output logic clockQualifyN,
    output logic sleepPin,
    // Shared data wire
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic dataOutEnable,
    output logic [DATA_W-1:0] dataWire
);
    typedef struct packed {
        op_kind_t kind;
        logic adv;
        logic stall;
        logic sleep;
        logic track;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lanes;
        logic [DATA_W-1:0] data;
    } slot_t;
    slot_t q[$];
    slot_t cur = '0;
    slot_t s1, s2;
    logic qualN = 1'b0;
    logic fresh = 1'b0;
    logic drv = 1'b0;
    logic [DATA_W-1:0] drvData = '0;
    logic [DATA_W-1:0] lastWire = '0;
    logic [DATA_W+1:0] got[$];

    task automatic put(input op_kind_t k, input logic a, st, sl, tr,
        input logic [ADDR_W-1:0] ad, input logic [LANES-1:0] ln,
        input logic [DATA_W-1:0] d);
        q.push_back('{k, a, st, sl, tr, ad, ln, d});
    endtask

    assign addr = cur.addr;
    assign advanceLoad = cur.adv;
    assign writeEnableN = cur.kind != OP_WRITE;
    assign byteLaneWriteSelectsN = ~cur.lanes;
    assign sleepPin = cur.sleep;
    assign clockQualifyN = qualN;
    // A deselect drops at most one select, picked by the low address bits; low bits of 3 drop none.
    assign chipSelectOneN = cur.kind == OP_DESEL && cur.addr[1:0] == 2'h0;
    assign chipSelectTwo = !(cur.kind == OP_DESEL && cur.addr[1:0] == 2'h1);
    assign chipSelectThreeN = cur.kind == OP_DESEL && cur.addr[1:0] == 2'h2;
    // Released wire shows a changing pattern so stale data never matches.
    assign dataWire = drv ? drvData : (dataOutEnable ? dataOut : ~lastWire);

    always @(negedge clk) begin
        slot_t nx;
        if (q.size() > 0 && q[0].stall) begin
            void'(q.pop_front());
            qualN <= 1'b1;
        end else begin
            nx = q.size() > 0 ? q.pop_front() : slot_t'('0);
            cur <= nx;
            qualN <= 1'b0;
        end
        drv <= s2.kind == OP_WRITE;
        drvData <= s2.data;
        lastWire <= dataWire;
        // Read data stands between the second and third enabled edges.
        if (fresh && s2.track) begin
            got.push_back({s2.kind == OP_READ, dataOutEnable, dataOut});
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            fresh <= 1'b0;
        end else begin
            fresh <= !qualN;
            if (!qualN) begin
                s1 <= cur;
                s2 <= s1;
            end
        end
    end
endmodule

// ==== dv/testbench.sv ====
/*
 * Self-checking bench for the burst memory port.
 * Assumes the controller model owns every command pin except burstOrderSel and outputEnableN, which the bench drives, and the data wire.
 */
`timescale 1ns/1ps
module testbench
    import sram_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic burstOrderSel = 1'b0;
    logic outputEnableN = 1'b0;
    int badCount = 0;
    int nTests = 0;
    int cycles = 0;
    logic [ADDR_W-1:0] addr;
    logic advanceLoad, writeEnableN, csOneN, csTwo, csThreeN;
    logic clockQualifyN, sleepPin, dataOutEnable;
    logic [LANES-1:0] laneSelN;
    logic [DATA_W-1:0] dataOut, dataWire;
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W+1:0] exp[$];

    sram_port u_sram_port (.clk(clk), .rst(rst), .addr(addr),
        .advanceLoad(advanceLoad), .burstOrderSel(burstOrderSel),
        .writeEnableN(writeEnableN), .byteLaneWriteSelectsN(laneSelN),
        .chipSelectOneN(csOneN), .chipSelectTwo(csTwo),
        .chipSelectThreeN(csThreeN), .clockQualifyN(clockQualifyN),
        .outputEnableN(outputEnableN), .sleepPin(sleepPin),
        .dataIn(dataWire), .dataOut(dataOut), .dataOutEnable(dataOutEnable));
    mem_ctrl_model u_mem_ctrl_model (.clk(clk), .rst(rst), .addr(addr),
        .advanceLoad(advanceLoad), .writeEnableN(writeEnableN),
        .byteLaneWriteSelectsN(laneSelN), .chipSelectOneN(csOneN),
        .chipSelectTwo(csTwo), .chipSelectThreeN(csThreeN),
        .clockQualifyN(clockQualifyN), .sleepPin(sleepPin),
        .dataOut(dataOut), .dataOutEnable(dataOutEnable),
        .dataWire(dataWire));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic fail(input string msg);
        badCount++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            fail("timeout");
            report_and_stop();
        end
    end

    // Queues one slot and the answer the port owes for it.
    task automatic op(input op_kind_t k, input logic [ADDR_W-1:0] a,
        input logic [LANES-1:0] ln, input logic [DATA_W-1:0] d,
        input logic adv = 1'b0, input logic sl = 1'b0);
        logic [DATA_W-1:0] v;
        v = mem.exists(int'(a)) ? mem[int'(a)] : '0;
        if (k == OP_WRITE) begin
            for (int i = 0; i < LANES; i++)
                if (ln[i])
                    v[i*LANE_BITS +: LANE_BITS] = d[i*LANE_BITS +: LANE_BITS];
            mem[int'(a)] = v;
        end
        exp.push_back({k == OP_READ, k == OP_READ && !outputEnableN, v});
        u_mem_ctrl_model.put(k, adv, 1'b0, sl, 1'b1, a, ln, d);
    endtask

    task automatic stall(input int n);
        repeat (n) u_mem_ctrl_model.put(OP_DESEL, 1'b0, 1'b1, 1'b0, 1'b0,
            '0, '0, '0);
    endtask

    // Compares answers in order; data only counts where drivers are on.
    task automatic drain_check(input string name);
        logic [DATA_W+1:0] g, e;
        int n;
        n = 0;
        while (u_mem_ctrl_model.got.size() < exp.size() && n < 100) begin
            @(negedge clk);
            n++;
        end
        repeat (3) @(negedge clk);
        nTests++;
        if (u_mem_ctrl_model.got.size() != exp.size())
            fail("answer count");
        while (exp.size() > 0 && u_mem_ctrl_model.got.size() > 0) begin
            e = exp.pop_front();
            g = u_mem_ctrl_model.got.pop_front();
            nTests++;
            if (g[DATA_W+1 -: 2] !== e[DATA_W+1 -: 2] || (e[DATA_W] && g !== e))
                fail(name);
        end
        exp.delete();
        u_mem_ctrl_model.got.delete();
        $display("Test %s done", name);
    endtask

    task automatic t_back_to_back();
        op(OP_WRITE, 18'h10, '1, 36'hA_5A5A_5A5A);
        op(OP_READ, 18'h10, '0, '0);
        op(OP_WRITE, 18'h11, '1, 36'h1_2345_6789);
        op(OP_READ, 18'h11, '0, '0);
        op(OP_READ, 18'h10, '0, '0);
        op(OP_WRITE, 18'h10, '1, 36'hF_0F0F_0F0F);
        op(OP_READ, 18'h10, '0, '0);
        drain_check("back_to_back");
    endtask

    task automatic t_lanes();
        op(OP_WRITE, 18'h20, '1, '0);
        op(OP_WRITE, 18'h20, '0, 36'hF_FFFF_FFFF);
        op(OP_READ, 18'h20, '0, '0);
        for (int i = 0; i < LANES; i++) begin
            op(OP_WRITE, 18'h20, LANES'(1) << i, 36'hF_FFFF_FFF0 + 36'(i));
            op(OP_READ, 18'h20, '0, '0);
        end
        drain_check("lanes");
    endtask

    task automatic burst(input op_kind_t k, input logic [1:0] st,
        input logic [DATA_W-1:0] d0);
        logic [ADDR_W-1:0] a;
        for (int n = 0; n < 4; n++) begin
            a = 18'h30;
            a[1:0] = burstOrderSel ? st ^ 2'(n) : st + 2'(n);
            op(k, a, '1, d0 + DATA_W'(n), n != 0);
        end
    endtask

    task automatic t_burst(input logic ord);
        burstOrderSel = ord;
        burst(OP_WRITE, 2'h1, ord ? 36'h5_0000_0010 : 36'h5_0000_0000);
        for (int n = 0; n < 4; n++)
            op(OP_READ, 18'h30 + 18'(n), '0, '0);
        burst(OP_READ, 2'h2, '0);
        drain_check("burst");
    endtask

    task automatic t_stall();
        op(OP_WRITE, 18'h40, '1, 36'h7_7777_0001);
        stall(2);
        op(OP_READ, 18'h40, '0, '0);
        stall(1);
        op(OP_WRITE, 18'h41, '1, 36'h6_6666_0002);
        stall(3);
        op(OP_READ, 18'h41, '0, '0);
        stall(2);
        op(OP_READ, 18'h40, '0, '0);
        drain_check("stall");
    endtask

    task automatic t_select_oe();
        for (int s = 0; s < 3; s++)
            op(OP_DESEL, ADDR_W'(s), '0, '0);
        outputEnableN = 1'b1;
        op(OP_READ, 18'h10, '0, '0);
        drain_check("select_oe");
        outputEnableN = 1'b0;
        op(OP_READ, 18'h11, '0, '0);
        drain_check("oe_back_on");
    endtask

    task automatic t_sleep();
        op(OP_WRITE, 18'h50, '1, 36'hC_3C3C_3C3C);
        repeat (4) op(OP_DESEL, '0, '0, '0, 1'b0, 1'b1);
        repeat (4) op(OP_DESEL, '0, '0, '0);
        op(OP_READ, 18'h50, '0, '0);
        drain_check("sleep");
    endtask

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_back_to_back();
        t_lanes();
        t_burst(1'b0);
        t_burst(1'b1);
        t_stall();
        t_select_oe();
        t_sleep();
        report_and_stop();
    end
endmodule

// ==== hdl/commit_fifo.sv ====
/*
 * Synchronous first-in first-out buffer held in flip-flops.
 * Assumes a single clock; the head word is shown while outValid is high.
 */
`timescale 1ns/1ps
module commit_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] DEPTH_COUNT = DEPTH[PTR_W:0];

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wrPtr_reg;
    logic [PTR_W-1:0] rdPtr_reg;
    logic [PTR_W:0] count_reg;
    logic push;
    logic pop;

    assign inReady = count_reg != DEPTH_COUNT;
    assign outValid = count_reg != '0;
    assign outData = store[rdPtr_reg];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_ff @(posedge clk) begin
        if (push) begin
            store[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ==== hdl/sram_port.sv ====
/*
 * Device side of a pipelined synchronous burst static memory port with
 * no turnaround cycles between reads and writes.
 * Assumes all inputs are synchronous to clk, that the controller drives
 * write data two enabled cycles after the write address, and that the
 * bench resolves the shared data wire from dataOutEnable.
 */
`timescale 1ns/1ps
module sram_port
    import sram_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Address and burst control
    input wire logic [ADDR_W-1:0] addr,
    input wire logic advanceLoad,
    input wire logic burstOrderSel,
    // Operation control
    input wire logic writeEnableN,
    input wire logic [LANES-1:0] byteLaneWriteSelectsN,
    input wire logic chipSelectOneN,
    input wire logic chipSelectTwo,
    input wire logic chipSelectThreeN,
    input wire logic clockQualifyN,
    input wire logic outputEnableN,
    input wire logic sleepPin,
    // Data pins
    input wire logic [DATA_W-1:0] dataIn,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOutEnable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Low address bits of a burst beat; count is the beat number.
    function automatic logic [BURST_BITS-1:0] burst_low(
        input logic [BURST_BITS-1:0] start,
        input logic [BURST_BITS-1:0] count,
        input logic interleaved
    );
        logic [BURST_BITS-1:0] low;
        low = interleaved ? (start ^ count) : (start + count);
        return low;
    endfunction

    // Replace only the lanes that are selected.
    function automatic logic [DATA_W-1:0] merge_lanes(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] fresh,
        input logic [LANES-1:0] lanes
    );
        logic [DATA_W-1:0] word;
        word = old;
        for (int i = 0; i < LANES; i++) begin
            if (lanes[i]) begin
                word[i*LANE_BITS +: LANE_BITS] = fresh[i*LANE_BITS +: LANE_BITS];
            end
        end
        return word;
    endfunction

    logic [DATA_W-1:0] mem [WORDS];
    stage_t curOp;
    stage_t s1_reg;
    stage_t s2_reg;
    op_kind_t burstKind_reg;
    logic [ADDR_W-1:0] burstBase_reg;
    logic [BURST_BITS-1:0] burstCnt_reg;
    logic [BURST_BITS-1:0] beatNext;
    power_t pwrState_reg;
    power_t pwrState_next;
    logic [DATA_W-1:0] dataOut_reg;
    logic readValid_reg;
    logic [DATA_W-1:0] readWord;
    logic selected;
    logic enable;
    logic pipeAdvance;
    logic active;
    commit_t pushEntry;
    commit_t headEntry;
    logic fifoInValid;
    logic fifoInReady;
    logic headValid;
    logic drainReady;
    logic drainFire;

    assign enable = !clockQualifyN;
    assign active = pwrState_reg == PWR_ACTIVE && !sleepPin;
    assign selected = !chipSelectOneN && chipSelectTwo && !chipSelectThreeN;
    assign beatNext = burstCnt_reg + 2'h1;

    // A full commit buffer with a write in stage two stalls the pipeline like a deasserted qualify.
    assign pipeAdvance = enable
        && !(s2_reg.kind == OP_WRITE && !fifoInReady);

    // Decode of the operation presented in this cycle.
    always_comb begin
        curOp = STAGE_IDLE;
        if (active) begin
            if (advanceLoad) begin
                if (burstKind_reg != OP_DESEL) begin
                    curOp.kind = burstKind_reg;
                    curOp.addr = {burstBase_reg[ADDR_W-1:BURST_BITS],
                        burst_low(burstBase_reg[BURST_BITS-1:0], beatNext,
                            burstOrderSel)};
                    curOp.lanes = burstKind_reg == OP_WRITE ?
                        ~byteLaneWriteSelectsN : '0;
                end
            end else if (selected) begin
                curOp.kind = writeEnableN ? OP_READ : OP_WRITE;
                curOp.addr = addr;
                curOp.lanes = writeEnableN ? '0 : ~byteLaneWriteSelectsN;
            end
        end
    end

    // Burst tracking: a load starts a burst, an advance steps it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            burstKind_reg <= OP_DESEL;
            burstBase_reg <= ADDR_RESET;
            burstCnt_reg <= BURST_CNT_RESET;
        end else if (pipeAdvance) begin
            if (!active) begin
                burstKind_reg <= OP_DESEL;
            end else if (!advanceLoad) begin
                burstKind_reg <= curOp.kind;
                burstBase_reg <= addr;
                burstCnt_reg <= BURST_CNT_RESET;
            end else if (burstKind_reg != OP_DESEL) begin
                burstCnt_reg <= beatNext;
            end
        end
    end

    // Input and middle pipeline stages, frozen while qualify is high.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= STAGE_IDLE;
            s2_reg <= STAGE_IDLE;
        end else if (pipeAdvance) begin
            s1_reg <= curOp;
            s2_reg <= s1_reg;
        end
    end

    // The write data phase is the stage-two slot of a write.
    assign fifoInValid = pipeAdvance && s2_reg.kind == OP_WRITE;
    assign pushEntry = '{addr: s2_reg.addr, data: dataIn,
        lanes: s2_reg.lanes};

    // Committed writes drain into the array on their own; while asleep the
    // array is held in retention and the buffer keeps pending words.
    assign drainReady = pwrState_reg != PWR_SLEEP;
    assign drainFire = headValid && drainReady;

    commit_fifo #(
        .WIDTH($bits(commit_t)),
        .DEPTH(COMMIT_DEPTH)
    ) u_commit (
        .clk(clk),
        .rst(rst),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(pushEntry),
        .outValid(headValid),
        .outReady(drainReady),
        .outData(headEntry)
    );

    // Storage has no reset so a stopped clock or reset keeps contents.
    always_ff @(posedge clk) begin
        if (drainFire) begin
            mem[headEntry.addr] <= merge_lanes(mem[headEntry.addr],
                headEntry.data, headEntry.lanes);
        end
    end

    // Reads leave stage one so their data stands in the slot before a
    // following write's data, which keeps the bus free of contention.
    // Older writes merge oldest first: buffer head, then the pins.
    // After sleep the port stays deselected until the buffer drains.
    always_comb begin
        readWord = mem[s1_reg.addr];
        if (headValid && headEntry.addr == s1_reg.addr) begin
            readWord = merge_lanes(readWord, headEntry.data,
                headEntry.lanes);
        end
        if (s2_reg.kind == OP_WRITE && s2_reg.addr == s1_reg.addr) begin
            readWord = merge_lanes(readWord, dataIn, s2_reg.lanes);
        end
    end

    // Output register: loaded by a read, turned off by a write or gap.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dataOut_reg <= DOUT_RESET;
            readValid_reg <= 1'b0;
        end else if (pipeAdvance) begin
            if (s1_reg.kind == OP_READ) begin
                dataOut_reg <= readWord;
                readValid_reg <= 1'b1;
            end else begin
                readValid_reg <= 1'b0;
            end
        end
    end

    assign dataOut = dataOut_reg;
    // The enable pin only gates the drivers and never touches the pipe.
    assign dataOutEnable = readValid_reg && !outputEnableN
        && pwrState_reg != PWR_SLEEP;

    // Sleep control: wake waits for pending writes so reads stay coherent.
    always_comb begin
        pwrState_next = pwrState_reg;
        case (pwrState_reg)
            PWR_ACTIVE: begin
                if (sleepPin) begin
                    pwrState_next = PWR_SLEEP;
                end
            end
            PWR_SLEEP: begin
                if (!sleepPin) begin
                    pwrState_next = PWR_WAKE;
                end
            end
            PWR_WAKE: begin
                if (sleepPin) begin
                    pwrState_next = PWR_SLEEP;
                end else if (!headValid && s1_reg.kind == OP_DESEL
                        && s2_reg.kind == OP_DESEL) begin
                    pwrState_next = PWR_ACTIVE;
                end
            end
            default: begin
                pwrState_next = PWR_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwrState_reg <= PWR_ACTIVE;
        end else begin
            pwrState_reg <= pwrState_next;
        end
    end

    sequence readIssued;
        pipeAdvance && curOp.kind == OP_READ;
    endsequence

    sequence writeIssued;
        pipeAdvance && curOp.kind == OP_WRITE;
    endsequence

    readLatency_a: assert property (
        readIssued ##1 pipeAdvance |=> readValid_reg)
        else $error("read data not ready for the second enabled edge");

    stallHold_a: assert property (
        !pipeAdvance |=> $stable(s1_reg) && $stable(s2_reg)
            && $stable(dataOut_reg) && $stable(readValid_reg))
        else $error("state changed while the clock was disqualified");

    writeTristate_a: assert property (
        writeIssued ##1 pipeAdvance |=> !dataOutEnable)
        else $error("data drivers on during a write data phase");

    writeCapture_a: assert property (
        writeIssued ##1 pipeAdvance ##1 pipeAdvance
            |-> $past(s1_reg.kind) == OP_WRITE && fifoInValid
            && fifoInReady)
        else $error("write data not captured two cycles after address");

    backToBack_a: assert property (
        writeIssued ##1 readIssued |=> s1_reg.kind == OP_READ
            && s2_reg.kind == OP_WRITE)
        else $error("read after write was not taken back to back");

    deselect_a: assert property (
        pipeAdvance && !advanceLoad && !selected
            |=> s1_reg.kind == OP_DESEL)
        else $error("operation taken without all chip selects");

    linearBurst_a: assert property (
        pipeAdvance && advanceLoad && !burstOrderSel
            && curOp.kind != OP_DESEL && s1_reg.kind != OP_DESEL
            |=> s1_reg.addr[1:0] == $past(s1_reg.addr[1:0]) + 2'h1)
        else $error("linear burst did not step by one");

    sleepQuiet_a: assert property (
        pwrState_reg == PWR_SLEEP |-> !dataOutEnable && !drainFire
            && curOp.kind == OP_DESEL)
        else $error("activity while asleep");

    laneSelect_a: assert property (
        writeIssued |=> s1_reg.lanes == ~$past(byteLaneWriteSelectsN))
        else $error("write lanes do not follow the lane selects");

    readData_a: assert property (
        pipeAdvance && s1_reg.kind == OP_READ |=> dataOut == $past(readWord))
        else $error("output register did not load the read word");
endmodule

// ==== inc/sram_pkg.sv ====
/*
 * Shared constants and types for the pipelined synchronous burst memory
 * port: organisation, lane layout, reset values and pipeline carriers.
 * Assumes one clock domain and that every module except commit_fifo imports the package.
 */
package sram_pkg;
    // Set to 1 for the 256K x 36 build, to 0 for the 512K x 18 build.
    localparam bit WIDE_BUILD = 1'b1;
    localparam int LANE_BITS = 9;
    localparam int LANES_WIDE = 4;
    localparam int LANES_NARROW = 2;
    localparam int ADDR_BITS_WIDE = 18;
    localparam int ADDR_BITS_NARROW = 19;
    localparam int LANES = WIDE_BUILD ? LANES_WIDE : LANES_NARROW;
    localparam int ADDR_W = WIDE_BUILD ? ADDR_BITS_WIDE : ADDR_BITS_NARROW;
    localparam int DATA_W = LANES * LANE_BITS;
    localparam int WORDS = 1 << ADDR_W;
    localparam int BURST_BITS = 2;
    localparam int COMMIT_DEPTH = 16;

    localparam logic [BURST_BITS-1:0] BURST_CNT_RESET = 2'h0;
    localparam logic [DATA_W-1:0] DOUT_RESET = '0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = '0;

    typedef enum logic [1:0] {OP_DESEL, OP_READ, OP_WRITE} op_kind_t;
    typedef enum logic [1:0] {PWR_ACTIVE, PWR_SLEEP, PWR_WAKE} power_t;

    typedef struct packed {
        op_kind_t kind;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lanes;
    } stage_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] lanes;
    } commit_t;

    localparam stage_t STAGE_IDLE = '{kind: OP_DESEL, addr: '0, lanes: '0};
endpackage
